// ===== rssl_dev.sv
// synthesizer end: serial port, segment words, ram load and playback
//
// Added by the designer: the Avalon-MM slave port, on the host end, not in this module.
`timescale 1ns/1ps
`include "rssl_map.svh"
module rssl_dev #(
  parameter int AW = 10,
  parameter int DW = 32
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clk_en,
  rssl_link_if.dev link,
  output logic [DW-1:0] ftw_out,
  output logic [AW-1:0] ram_addr_out,
  output logic ram_enabled,
  output logic sweep_active
);
  typedef enum logic [1:0] {S_IDLE, S_INSTR, S_DATA, S_RAMW} st_t;
  // whole module state
  typedef struct packed {
    logic [1:0] sclk_s1, cs_s1, sd_s1, upd_s1, ps0_s1, ps1_s1;
    logic sclk_s2, cs_s2, sd_s2, upd_s2, ps0_s2, ps1_s2;
    logic sclk_d, upd_d, ps0_d, ps1_d;
    st_t st;
    logic [5:0] bitcnt;
    logic [7:0] instr;
    logic [39:0] shreg;
    logic [39:0] buf0, buf1, scw0, scw1;
    logic [31:0] first_control_register_buf, first_control_register;
    logic [AW-1:0] waddr, wfinal;
    logic wdone;
    logic [1:0] divcnt;
    logic [15:0] dwell;
    logic [AW-1:0] addr;
    logic seg;
    logic run;
    logic [DW-1:0] ftw;
  } st_all_t;
  st_all_t s_reg, s_next;
  logic [DW-1:0] ram [0:(1<<AW)-1]; // waveform ram
  logic ram_we;
  logic [AW-1:0] ram_wa;
  logic [DW-1:0] ram_wd;
  rssl_pkg::rssl_scw_t cur;
  // ram write port; the registered read is in the next-state logic
  always_ff @(posedge sys_clk) begin
    if (clk_en && ram_we) begin
      ram[ram_wa] <= ram_wd; // (RL9) (RL11)
    end
  end
  // next-state logic
  always_comb begin
    logic rise, ps_change;
    rise = 1'b0; // edge flags start clear on every pass
    ps_change = 1'b0;
    // default decode of the idle segment, refined below
    cur = rssl_pkg::rssl_decode(s_reg.scw0);
    s_next = s_reg;
    ram_we = 1'b0;
    ram_wa = s_reg.waddr;
    ram_wd = s_reg.shreg[31:0];
    // two-flop synchronisers on every pin
    s_next.sclk_s1 = {1'b0, link.sclk};
    s_next.cs_s1 = {1'b0, link.cs_n};
    s_next.sd_s1 = {1'b0, link.sdio};
    s_next.upd_s1 = {1'b0, link.io_update};
    s_next.ps0_s1 = {1'b0, link.profile_select_low};
    s_next.ps1_s1 = {1'b0, link.profile_select_high};
    s_next.sclk_s2 = s_reg.sclk_s1[0];
    s_next.cs_s2 = s_reg.cs_s1[0];
    s_next.sd_s2 = s_reg.sd_s1[0];
    s_next.upd_s2 = s_reg.upd_s1[0];
    s_next.ps0_s2 = s_reg.ps0_s1[0];
    s_next.ps1_s2 = s_reg.ps1_s1[0];
    s_next.sclk_d = s_reg.sclk_s2;
    s_next.upd_d = s_reg.upd_s2;
    s_next.ps0_d = s_reg.ps0_s2;
    s_next.ps1_d = s_reg.ps1_s2;
    rise = s_reg.sclk_s2 && !s_reg.sclk_d;
    // serial receiver, msb first
    if (s_reg.cs_s2) begin
      s_next.st = S_IDLE;
      s_next.bitcnt = 6'h00; // a new frame always opens with the instruction
    end else if (rise) begin
      s_next.shreg = {s_reg.shreg[38:0], s_reg.sd_s2};
      s_next.bitcnt = s_reg.bitcnt + 6'h01;
      unique case (s_reg.st)
        S_IDLE, S_INSTR: begin
          s_next.st = S_INSTR;
          if (s_reg.bitcnt == 6'h07) begin
            s_next.instr = {s_reg.shreg[6:0], s_reg.sd_s2};
            s_next.bitcnt = 6'h00;
            if ({s_reg.shreg[6:0], s_reg.sd_s2} == `RSSL_INSTR_RAM) begin // (RL7)
              // sample profile pins to pick the target segment
              cur = rssl_pkg::rssl_decode(s_reg.ps1_s2 ? s_reg.scw1 :
                (s_reg.ps0_s2 ? s_reg.scw1 : s_reg.scw0)); // (RL8)
              s_next.waddr = cur.begin_addr; // (RL9)
              s_next.wfinal = cur.final_addr;
              s_next.wdone = 1'b0;
              s_next.st = S_RAMW;
            end else begin
              s_next.st = S_DATA;
            end
          end
        end
        S_DATA: begin
          // 32-bit control register or 40-bit segment words latched to buffer
          if (s_reg.instr == `RSSL_INSTR_FIRST_CONTROL_REGISTER && s_reg.bitcnt == 6'd31) begin
            s_next.first_control_register_buf = {s_reg.shreg[30:0], s_reg.sd_s2};
          end
          if (s_reg.bitcnt == 6'd39) begin
            if (s_reg.instr == `RSSL_INSTR_SCW0) begin
              s_next.buf0 = {s_reg.shreg[38:0], s_reg.sd_s2}; // (RL2) (RL13)
            end
            if (s_reg.instr == `RSSL_INSTR_SCW1) begin
              s_next.buf1 = {s_reg.shreg[38:0], s_reg.sd_s2};
            end
          end
        end
        S_RAMW: begin
          // one ram word per completed group of 32 bits, until the final address is written
          if (s_reg.bitcnt == 6'd31) begin
            s_next.bitcnt = 6'h00;
            if (!s_reg.wdone) begin
              ram_we = 1'b1;
              ram_wd = {s_reg.shreg[30:0], s_reg.sd_s2};
              if (s_reg.waddr == s_reg.wfinal) begin
                s_next.wdone = 1'b1; // word count ends at final address
              end else begin
                s_next.waddr = s_reg.waddr + 1'b1;
              end
            end
          end
        end
        default: s_next.st = S_IDLE;
      endcase
    end
    // io update commits buffered words
    if (s_reg.upd_s2 && !s_reg.upd_d) begin
      s_next.scw0 = s_reg.buf0;
      s_next.scw1 = s_reg.buf1;
      s_next.first_control_register = s_reg.first_control_register_buf;
    end
    // playback: sync tick every fourth system clock
    s_next.divcnt = s_reg.divcnt + 2'h1;
    cur = rssl_pkg::rssl_decode(s_reg.seg ? s_reg.scw1 : s_reg.scw0);
    ps_change = (s_reg.ps0_s2 != s_reg.ps0_d) || (s_reg.ps1_s2 != s_reg.ps1_d);
    if (!s_reg.first_control_register[`RSSL_FIRST_CONTROL_REGISTER_RAM_EN]) begin
      s_next.run = 1'b0; // (RL5)
    end else if (ps_change) begin
      s_next.seg = s_reg.ps0_s2 | s_reg.ps1_s2; // (RL10)
      // restart from the begin address of the newly chosen segment
      cur = rssl_pkg::rssl_decode((s_reg.ps0_s2 | s_reg.ps1_s2) ?
        s_reg.scw1 : s_reg.scw0);
      s_next.addr = cur.begin_addr; // (RL16)
      s_next.dwell = 16'h0001;
      s_next.divcnt = 2'h0;
      s_next.run = s_reg.ps0_s2 && !s_reg.ps0_d; // (RL12)
    end else if (s_reg.run && s_reg.divcnt == 2'h3) begin // (RL1)
      if (s_reg.dwell >= cur.rate || cur.rate == 16'h0000) begin // (RL15)
        s_next.dwell = 16'h0001;
        if (cur.mode != `RSSL_MODE_RAMP_UP) begin
          s_next.run = 1'b0;
        end else if (s_reg.addr == cur.final_addr) begin // (RL3)
          s_next.run = 1'b0;
          s_next.addr = cur.nodwell ? cur.begin_addr : s_reg.addr; // (RL4) (RL14)
        end else begin
          s_next.addr = s_reg.addr + 1'b1;
        end
      end else begin
        s_next.dwell = s_reg.dwell + 16'h0001;
      end
    end
    // registered read: the word trails the address by one clock
    s_next.ftw = ram[s_reg.addr];
  end
  // state register, frozen while clock enable is low
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s_reg <= '0;
      s_reg.cs_s1 <= 2'h1; // frame pin idles high, so its first flop does too
      s_reg.cs_s2 <= 1'b1;
      s_reg.buf0 <= `RSSL_SCW_RESET;
      s_reg.buf1 <= `RSSL_SCW_RESET;
    end else if (clk_en) begin
      s_reg <= s_next;
    end
  end
  // outputs straight from flops
  assign ftw_out = s_reg.ftw;
  assign ram_addr_out = s_reg.addr;
  assign ram_enabled = s_reg.first_control_register[`RSSL_FIRST_CONTROL_REGISTER_RAM_EN];
  assign sweep_active = s_reg.run;
endmodule

// ===== rssl_map.svh
// constants for the ram segment sweep loader: offsets, fields, timing
`ifndef RSSL_MAP_SVH
`define RSSL_MAP_SVH
// Functional notes
// (RL1) at most one address step per sync cycle
// (RL2) control word: rate, final, begin, mode, nodwell
// (RL3) mode 001 ramps begin to final, holds
// (RL4) nodwell clear: stay at final address
// (RL5) host sets ram enable before ram use
// (RL6) host updates control words before ram data
// (RL7) instruction 00001011 starts a ram write
// (RL8) device samples profile pins on ram write
// (RL9) words stored begin to final, in order
// (RL10) profile 0 is 00, profile 1 is 01
// (RL11) each ram word is 32-bit tuning word
// (RL12) profile select low rising starts segment playback
// (RL13) fixed bit placement of control word fields
// (RL14) nodwell set: return to begin and hold
// (RL15) ramp rate counts sync cycles, zero invalid
// (RL16) profile change restarts at new segment begin
`define RSSL_INSTR_FIRST_CONTROL_REGISTER 8'h00
`define RSSL_INSTR_SCW0 8'h07
`define RSSL_INSTR_SCW1 8'h08
`define RSSL_INSTR_RAM 8'h0b
`define RSSL_FIRST_CONTROL_REGISTER_RAM_EN 31
`define RSSL_SCW_RATE_HI 39
`define RSSL_SCW_RATE_LO 24
`define RSSL_SCW_NODWELL 4
`define RSSL_SCW_MODE_HI 7
`define RSSL_SCW_MODE_LO 5
`define RSSL_MODE_RAMP_UP 3'h1
`define RSSL_SYNC_DIV 4
`define RSSL_CSR_CMD 4'h0
`define RSSL_CSR_DATA 4'h4
`define RSSL_CSR_STATUS 4'h8
`define RSSL_SCW_RESET 40'h00_0000_0000
`endif

// ===== rssl_pkg.sv
// types used by the synthesizer end of the ram segment sweep loader
package rssl_pkg;
  // one serial transfer: instruction byte then up to five data bytes
  typedef struct packed {
    logic [7:0] instr;
    logic [39:0] data;
    logic [2:0] nbytes;
  } rssl_xfer_t;
  // decoded segment control word
  typedef struct packed {
    logic [15:0] rate;
    logic [9:0] final_addr;
    logic [9:0] begin_addr;
    logic [2:0] mode;
    logic nodwell;
  } rssl_scw_t;
  // unpack control word fields from their scattered bit spots
  function automatic rssl_scw_t rssl_decode(input logic [39:0] w);
    rssl_scw_t s;
    s.rate = w[39:24];
    s.final_addr = {w[9:8], w[23:16]};
    s.begin_addr = {w[3:0], w[15:10]};
    s.mode = w[7:5];
    s.nodwell = w[4];
    return s;
  endfunction
endpackage

// ===== rssl_link_if.sv
// serial link and profile pins between host and synthesizer
`timescale 1ns/1ps
interface rssl_link_if;
  logic sclk;
  logic cs_n;
  logic sdio;
  logic io_update;
  logic profile_select_low;
  logic profile_select_high;
  modport host (output sclk, output cs_n, output sdio, output io_update,
    output profile_select_low, output profile_select_high);
  modport dev (input sclk, input cs_n, input sdio, input io_update,
    input profile_select_low, input profile_select_high);
endinterface

// ===== rssl_host.sv
// host end: avalon slave registers driving serial port and profile pins
`timescale 1ns/1ps
`include "rssl_map.svh"
module rssl_host #(
  parameter int HALF = 2
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  rssl_link_if.host link
);
  // whole module state
  typedef struct packed {
    logic [7:0] instr;
    logic [39:0] data;
    logic [5:0] nbits;
    logic [5:0] cnt;
    logic [7:0] div;
    logic busy;
    logic sclk, cs_n, sdio, upd;
    logic [1:0] ps;
    logic [31:0] rdata;
    logic wait_r;
    logic upd_q; // update pulse, one clock behind the frame end
  } hs_t;
  hs_t s_reg, s_next;
  // command: [7:0] instr, [13:8] bits of data, [16] io update, [18:17] profile
  always_comb begin
    s_next = s_reg;
    s_next.wait_r = 1'b1;
    // update pulse trails the frame end by a clock, so cs_n is already high
    s_next.upd_q = s_reg.upd && !s_reg.busy;
    if (s_reg.upd_q) begin
      s_next.upd = 1'b0;
    end
    if ((avs_read || avs_write) && s_reg.wait_r) begin
      s_next.wait_r = 1'b0;
      if (avs_write && avs_address == `RSSL_CSR_DATA) begin
        s_next.data = {s_reg.data[7:0], avs_writedata};
      end else if (avs_write && avs_address == `RSSL_CSR_CMD && !s_reg.busy) begin
        s_next.instr = avs_writedata[7:0];
        s_next.nbits = avs_writedata[13:8];
        s_next.upd = avs_writedata[16]; // (RL6)
        s_next.ps = avs_writedata[18:17]; // (RL10)
        s_next.busy = 1'b1;
        s_next.cnt = 6'h00;
        s_next.div = 8'h00;
        s_next.cs_n = 1'b0;
        s_next.sdio = avs_writedata[7]; // (RL7)
      end
      s_next.rdata = (avs_address == `RSSL_CSR_STATUS) ? {31'h0, s_reg.busy} :
        (avs_address == `RSSL_CSR_DATA) ? s_reg.data[31:0] : 32'h0000_0000;
    end else if (!s_reg.wait_r) begin
      s_next.wait_r = 1'b1;
    end
    // shift instruction then data, msb first
    if (s_reg.busy) begin
      s_next.div = s_reg.div + 8'h01;
      if (s_reg.div == 8'(HALF - 1)) begin
        s_next.sclk = 1'b1;
      end else if (s_reg.div == 8'(2 * HALF - 1)) begin
        s_next.sclk = 1'b0;
        s_next.div = 8'h00;
        s_next.cnt = s_reg.cnt + 6'h01;
        if (s_reg.cnt == 6'(7) + s_reg.nbits) begin
          s_next.busy = 1'b0;
          s_next.cs_n = 1'b1;
        end else if (s_reg.cnt < 6'h07) begin
          s_next.sdio = s_reg.instr[3'(6 - s_reg.cnt)];
        end else begin
          s_next.sdio = s_reg.data[6'(s_reg.nbits - 6'h01 - (s_reg.cnt - 6'h07))];
        end
      end
    end
  end
  // state register
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s_reg <= '0;
      s_reg.cs_n <= 1'b1;
      s_reg.wait_r <= 1'b1;
    end else if (clk_en) begin
      s_reg <= s_next;
    end
  end
  assign avs_readdata = s_reg.rdata;
  assign avs_waitrequest = s_reg.wait_r;
  assign link.sclk = s_reg.sclk;
  assign link.cs_n = s_reg.cs_n;
  assign link.sdio = s_reg.sdio;
  assign link.io_update = s_reg.upd_q; // (RL6)
  assign link.profile_select_low = s_reg.ps[0];
  assign link.profile_select_high = s_reg.ps[1];
endmodule

// ===== rssl_sweep_monitor.sv
// checker for serial link timing and playback address stepping
`timescale 1ns/1ps
module rssl_sweep_monitor (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdio,
  input wire logic io_update,
  input wire logic profile_select_low,
  input wire logic profile_select_high,
  input wire logic [9:0] ram_addr_out,
  input wire logic sweep_active
);
  logic [1:0] pins_reg; // profile pins one cycle ago
  logic [3:0] quiet_reg; // cycles since the profile pins moved, saturating
  // restarts follow a profile change, so address checks wait until pins settle
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pins_reg <= 2'h0;
      quiet_reg <= 4'h0;
    end else begin
      pins_reg <= {profile_select_high, profile_select_low};
      if (pins_reg != {profile_select_high, profile_select_low}) begin
        quiet_reg <= 4'h0;
      end else if (quiet_reg != 4'hf) begin
        quiet_reg <= quiet_reg + 4'h1;
      end
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  step_spacing_a: assert property ($changed(ram_addr_out) && $past(sweep_active)
    && quiet_reg > 4'h8 |=> $stable(ram_addr_out)[*3]) else $error("address step too soon");
  ramp_up_a: assert property ($changed(ram_addr_out) && $past(sweep_active) && sweep_active
    && quiet_reg > 4'h8 |-> ram_addr_out == $past(ram_addr_out) + 10'h001)
    else $error("ramp did not step by one");
  hold_idle_a: assert property (!sweep_active && !$past(sweep_active) && quiet_reg > 4'h8
    |-> $stable(ram_addr_out) || ram_addr_out < $past(ram_addr_out))
    else $error("idle address moved up");
  sweep_start_a: assert property ($rose(profile_select_low) |-> ##[1:8] sweep_active)
    else $error("rising profile pin did not start a sweep");
  sclk_idle_a: assert property (cs_n && $past(cs_n) |-> $stable(sclk))
    else $error("serial clock moved outside a frame");
  sclk_half_a: assert property (!cs_n && $changed(sclk) |=> $stable(sclk))
    else $error("serial clock half period too short");
  update_gap_a: assert property ($rose(io_update) |-> cs_n && $past(cs_n))
    else $error("update raised inside a frame");
  pins_frame_a: assert property (!cs_n && !$past(cs_n)
    |-> $stable({profile_select_high, profile_select_low})) else $error("profile moved in frame");
endmodule

// ===== testbench.sv
// self-checking bench: register host driving the synthesizer end
`timescale 1ns/1ps
module testbench;
  logic sys_clk = 1'h0;
  logic rst = 1'h1;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'h0;
  logic avs_write = 1'h0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] avs_readdata; // register read data
  logic avs_waitrequest; // low for one cycle answers a request
  logic [31:0] ftw_out; // word at the playback address
  logic [9:0] ram_addr_out; // playback address
  logic ram_enabled;
  logic sweep_active;
  int miscompares = 0;
  int checks_done = 0;
  int c; // cycle count from waits
  rssl_link_if lk();
  rssl_host #(.HALF(2)) rssl_host_i (.sys_clk(sys_clk), .rst(rst), .clk_en(1'h1),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .link(lk.host));
  rssl_dev rssl_dev_i (.sys_clk(sys_clk), .rst(rst), .clk_en(1'h1), .link(lk.dev),
    .ftw_out(ftw_out), .ram_addr_out(ram_addr_out), .ram_enabled(ram_enabled),
    .sweep_active(sweep_active));
  rssl_sweep_monitor rssl_sweep_monitor_i (.sys_clk(sys_clk), .rst(rst), .sclk(lk.sclk),
    .cs_n(lk.cs_n), .sdio(lk.sdio), .io_update(lk.io_update),
    .profile_select_low(lk.profile_select_low), .profile_select_high(lk.profile_select_high),
    .ram_addr_out(ram_addr_out), .sweep_active(sweep_active));
  // 100 ns period
  always #50 sys_clk = ~sys_clk;
  // counts, verdict and end of run
  task results;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // compare seen against expected
  task chk(input logic [39:0] s, input logic [39:0] e);
    checks_done++;
    if (s !== e) begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // one bus cycle held until waitrequest is sampled low
  task automatic av(input logic [3:0] a, input logic w, input logic [31:0] d,
    output logic [31:0] q);
    int n;
    @(posedge sys_clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'h0 && n < 50);
    q = avs_readdata;
    avs_write <= 1'h0;
    avs_read <= 1'h0;
    if (n >= 50) begin
      miscompares++;
      results();
    end
  endtask
  // send one frame; optionally poll status until the link is idle
  task automatic snd(input logic [7:0] ins, input logic [5:0] nb, input logic [39:0] d,
    input logic up, input logic [1:0] pr, input logic w);
    logic [31:0] q;
    int n;
    if (nb == 6'h28) av(4'h4, 1'h1, {24'h00_0000, d[39:32]}, q);
    av(4'h4, 1'h1, d[31:0], q);
    av(4'h0, 1'h1, {13'h0000, pr, up, 2'h0, nb, ins}, q);
    n = 0;
    q = {31'h0000_0000, w};
    while (q[0] !== 1'h0 && n < 500) begin
      av(4'h8, 1'h0, 32'h0000_0000, q);
      n++;
    end
    if (n >= 500) begin
      miscompares++;
      results();
    end
    // let a committed update cross the pin synchronisers before checking
    repeat (8) @(posedge sys_clk);
  endtask
  // wait for a playback address, counting cycles
  task automatic wt(input logic [9:0] a, output int k);
    k = 0;
    while (ram_addr_out !== a && k < 3000) begin
      @(posedge sys_clk);
      k++;
    end
    if (k >= 3000) begin
      miscompares++;
      results();
    end
  endtask
  // segment word in ramp-up mode from its scattered fields
  function automatic logic [39:0] mk(input logic [15:0] r, input logic [9:0] f,
    input logic [9:0] b, input logic nd);
    return {r, f[7:0], b[5:0], f[9:8], 3'h1, nd, b[9:6]};
  endfunction
  // main sequence
  initial begin
    repeat (3) @(posedge sys_clk);
    rst <= 1'h0;
    snd(8'h00, 6'h20, 40'h00_8000_0000, 1'h1, 2'h0, 1'h1);
    chk(ram_enabled, 1'h1);
    snd(8'h07, 6'h28, mk(16'h0001, 10'h005, 10'h005, 1'h0), 1'h0, 2'h0, 1'h1);
    snd(8'h08, 6'h28, mk(16'h003c, 10'h067, 10'h064, 1'h0), 1'h1, 2'h0, 1'h1);
    snd(8'h0b, 6'h20, 40'h00_1234_5678, 1'h0, 2'h0, 1'h1);
    snd(8'h0b, 6'h20, 40'h00_cafe_0001, 1'h0, 2'h1, 1'h1);
    $display("load done");
    snd(8'h00, 6'h20, 40'h00_8000_0000, 1'h0, 2'h0, 1'h1);
    wt(10'h005, c);
    chk(ftw_out, 40'h00_1234_5678);
    snd(8'h00, 6'h20, 40'h00_8000_0000, 1'h0, 2'h1, 1'h0);
    wt(10'h064, c);
    repeat (4) @(posedge sys_clk);
    chk(ftw_out, 40'h00_cafe_0001);
    chk(sweep_active, 1'h1);
    wt(10'h065, c);
    wt(10'h066, c);
    chk(c, 40'h00_0000_00f0);
    snd(8'h00, 6'h20, 40'h00_8000_0000, 1'h0, 2'h0, 1'h1);
    wt(10'h005, c);
    chk(ram_addr_out, 10'h005);
    $display("playback done");
    snd(8'h00, 6'h20, 40'h00_8000_0000, 1'h0, 2'h1, 1'h0);
    wt(10'h067, c);
    repeat (300) @(posedge sys_clk);
    chk(ram_addr_out, 10'h067);
    chk(sweep_active, 1'h0);
    $display("hold done");
    snd(8'h08, 6'h28, mk(16'h0001, 10'h067, 10'h064, 1'h1), 1'h1, 2'h0, 1'h1);
    snd(8'h00, 6'h20, 40'h00_8000_0000, 1'h0, 2'h1, 1'h0);
    wt(10'h067, c);
    repeat (50) @(posedge sys_clk);
    chk(ram_addr_out, 10'h064);
    $display("no-dwell done");
    results();
  end
endmodule
